//--- rtl/ssa_defs.svh
// Constants for the serial port slave address and receive path.
`ifndef SSA_DEFS_SVH
`define SSA_DEFS_SVH
`define SSA_MODE_7BIT 4'h6
`define SSA_MODE_10BIT 4'h7
`define SSA_MODE_7BIT_SP 4'hE
`define SSA_MODE_10BIT_SP 4'hF
`define SSA_TEN_BIT_PREFIX 5'h1E
`define SSA_FLAG_INT_POS 3
`define SSA_BYTE_RESET 8'h00
`define SSA_BITS_PER_BYTE 4'h8
`define SSA_ACK_SLOT 4'h9
`endif

//--- rtl/ssa_pin_if.sv
// Interface carrying the synchronised bus levels and detected bus events.
`timescale 1ns/100ps
interface ssa_pin_if;
    logic scl_level;
    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    modport source (output scl_level, sda_level, scl_rise, scl_fall, start_seen, stop_seen);
    modport sink (input scl_level, sda_level, scl_rise, scl_fall, start_seen, stop_seen);
endinterface

//--- rtl/ssa_pin_sync.sv
// Two-stage synchroniser and edge, start and stop detector for the bus pins.
`timescale 1ns/100ps
module ssa_pin_sync (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    ssa_pin_if.source pins
);
    import ssa_pkg::*;

    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic scl_prev;
    logic sda_prev;

    // Only the second stage and the delayed copies feed any logic.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_meta <= 2'b11;
            sda_meta <= 2'b11;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= {scl_meta[0], scl_in};
            sda_meta <= {sda_meta[0], sda_in};
            scl_prev <= scl_meta[1];
            sda_prev <= sda_meta[1];
        end
    end

    // Start is SDA falling while SCL is high; stop is SDA rising while SCL is high.
    assign pins.scl_level = scl_meta[1];
    assign pins.sda_level = sda_meta[1];
    assign pins.scl_rise = scl_meta[1] & ~scl_prev;
    assign pins.scl_fall = ~scl_meta[1] & scl_prev;
    assign pins.start_seen = scl_meta[1] & scl_prev & sda_prev & ~sda_meta[1];
    assign pins.stop_seen = scl_meta[1] & scl_prev & ~sda_prev & sda_meta[1];
endmodule // ssa_pin_sync

//--- rtl/ssa_pkg.sv
// Types shared by the serial port slave receive path.
package ssa_pkg;
    typedef logic [7:0] ssa_byte_t;
    typedef logic [3:0] ssa_mode_t;
    typedef enum logic [2:0] {
        SSA_IDLE,
        SSA_SHIFT,
        SSA_ACK,
        SSA_HOLD,
        SSA_IGNORE
    } ssa_state_e;
endpackage

//--- rtl/ssa_slave_rx.sv
// Slave address recognition and receive path of the synchronous serial port.
`timescale 1ns/100ps
`include "ssa_defs.svh"
module ssa_slave_rx (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    input wire logic port_enable_bit,
    input wire ssa_pkg::ssa_mode_t port_mode,
    input wire logic match_write,
    input wire ssa_pkg::ssa_byte_t match_wdata,
    input wire logic buffer_read,
    input wire logic int_flag_clear,
    input wire logic overflow_clear,
    input wire logic port_int_enable,
    output ssa_pkg::ssa_byte_t receive_buffer,
    output ssa_pkg::ssa_byte_t address_match_register,
    output logic buffer_full_flag,
    output logic receive_overflow_flag,
    output logic port_interrupt_flag,
    output logic update_address_flag,
    output logic read_write_flag,
    output logic data_address_flag,
    output logic port_irq
);
    import ssa_pkg::*;

    ssa_pin_if pins ();

    ssa_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .pins(pins)
    );

    ssa_state_e state;
    ssa_byte_t bit_shift_register;
    logic [3:0] bit_count;
    logic ack_now;
    logic ack_accept;
    logic is_address;
    logic high_seen;
    logic want_hold;
    logic set_int;
    logic set_full;
    logic set_ovf;
    logic load_buf;
    logic set_ua;
    logic set_rw;
    logic clr_rw;

    // Mode and enable decode.
    wire ten_bit = (port_mode == `SSA_MODE_10BIT) || (port_mode == `SSA_MODE_10BIT_SP);
    wire slave_on = port_enable_bit && (ten_bit || port_mode == `SSA_MODE_7BIT
                    || port_mode == `SSA_MODE_7BIT_SP);
    wire ovf_cond = buffer_full_flag | receive_overflow_flag;
    wire [7:0] cur_byte = bit_shift_register;
    wire is_high_byte = cur_byte[7:3] == `SSA_TEN_BIT_PREFIX;
    wire match7 = cur_byte[7:1] == address_match_register[7:1];
    wire match10hi = is_high_byte && cur_byte[2:1] == address_match_register[2:1];
    wire match10lo = cur_byte == address_match_register;
    // In ten-bit mode the first byte matches on prefix and bits 2:1, the second on the whole byte or as a repeated high byte.
    wire addr_match = !ten_bit ? match7 : (high_seen ? match10lo || match10hi : match10hi);
    wire eighth_fall = pins.scl_fall && bit_count == `SSA_BITS_PER_BYTE;

    // Byte framing state machine; a Start restarts address reception whenever slave_on is set.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= SSA_IDLE;
            bit_shift_register <= `SSA_BYTE_RESET;
            bit_count <= 4'h0;
            ack_now <= 1'b0;
            is_address <= 1'b0;
            high_seen <= 1'b0;
            want_hold <= 1'b0;
        end else if (!slave_on) begin
            state <= SSA_IDLE;
            bit_count <= 4'h0;
            ack_now <= 1'b0;
            want_hold <= 1'b0;
            high_seen <= 1'b0;
        end else if (pins.start_seen) begin
            state <= SSA_SHIFT;
            bit_count <= 4'h0;
            ack_now <= 1'b0;
            is_address <= 1'b1;
            want_hold <= 1'b0;
        end else if (pins.stop_seen) begin
            state <= SSA_IDLE;
            ack_now <= 1'b0;
            high_seen <= 1'b0;
        end else begin
            case (state)
                SSA_SHIFT: begin
                    if (pins.scl_rise && bit_count < `SSA_BITS_PER_BYTE) begin
                        bit_shift_register <= {bit_shift_register[6:0], pins.sda_level};
                        bit_count <= bit_count + 4'h1;
                    end else if (eighth_fall) begin
                        if (is_address && !addr_match) begin
                            state <= SSA_IGNORE;
                            high_seen <= 1'b0;
                        end else begin
                            state <= SSA_ACK;
                            ack_now <= ack_accept;
                            if (is_address && ten_bit && !(high_seen && cur_byte[0])) begin
                                want_hold <= 1'b1;
                            end
                            if (is_address && ten_bit && is_high_byte && !cur_byte[0]) begin
                                high_seen <= 1'b1;
                            end
                        end
                    end
                end
                SSA_ACK: begin
                    if (pins.scl_fall) begin
                        ack_now <= 1'b0;
                        bit_count <= 4'h0;
                        state <= want_hold ? SSA_HOLD : SSA_SHIFT;
                        // The ten-bit high byte keeps the frame in address phase for the second byte.
                        is_address <= ten_bit && is_address && high_seen && want_hold
                                      && is_high_byte;
                    end
                end
                SSA_HOLD: begin
                    if (match_write) begin
                        want_hold <= 1'b0;
                        state <= SSA_SHIFT;
                    end
                end
                default: begin
                    state <= state; // Idle and ignore wait for the next Start.
                end
            endcase
        end
    end

    // Accept decisions taken at the eighth falling edge; the interrupt flag is set at the ninth.
    assign ack_accept = !ovf_cond;
    wire at_ack_end = state == SSA_ACK && pins.scl_fall;
    assign load_buf = eighth_fall && state == SSA_SHIFT && (!is_address || addr_match)
                      && !ovf_cond;
    assign set_full = load_buf;
    assign set_ovf = eighth_fall && state == SSA_SHIFT && !is_address && ovf_cond;
    assign set_int = at_ack_end;
    assign set_ua = eighth_fall && state == SSA_SHIFT && is_address && addr_match && ten_bit
                    && !(high_seen && cur_byte[0] && is_high_byte);
    assign set_rw = eighth_fall && state == SSA_SHIFT && is_address && addr_match
                    && cur_byte[0];
    assign clr_rw = eighth_fall && state == SSA_SHIFT && is_address && addr_match
                    && !cur_byte[0];

    // Status flags: hardware set wins over a firmware clear in the same cycle.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            receive_buffer <= `SSA_BYTE_RESET;
            address_match_register <= `SSA_BYTE_RESET;
            buffer_full_flag <= 1'b0;
            receive_overflow_flag <= 1'b0;
            port_interrupt_flag <= 1'b0;
            update_address_flag <= 1'b0;
            read_write_flag <= 1'b0;
            data_address_flag <= 1'b0;
        end else begin
            if (load_buf) begin
                receive_buffer <= bit_shift_register;
            end
            if (match_write) begin
                address_match_register <= match_wdata;
            end
            buffer_full_flag <= set_full | (buffer_full_flag & ~buffer_read);
            receive_overflow_flag <= set_ovf | (receive_overflow_flag & ~overflow_clear);
            port_interrupt_flag <= set_int | (port_interrupt_flag & ~int_flag_clear);
            update_address_flag <= set_ua | (update_address_flag & ~match_write);
            if (set_rw) begin
                read_write_flag <= 1'b1;
            end else if (clr_rw) begin
                read_write_flag <= 1'b0;
            end
            if (eighth_fall && state == SSA_SHIFT) begin
                data_address_flag <= !is_address;
            end
        end
    end

    // Pin drivers and the gated interrupt, all registered.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            port_irq <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= (state == SSA_ACK) && ack_now;
            scl_out <= 1'b0;
            scl_oe <= state == SSA_HOLD && !match_write;
            port_irq <= port_interrupt_flag & port_int_enable;
        end
    end
endmodule // ssa_slave_rx

//--- sim/ssa_assertions.sv
// Concurrent checks on the ports of the slave receive path.
`timescale 1ns/100ps
module ssa_assertions (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic match_write,
    input wire logic int_flag_clear,
    input wire logic overflow_clear,
    input wire logic port_int_enable,
    input wire ssa_pkg::ssa_byte_t receive_buffer,
    input wire logic buffer_full_flag,
    input wire logic receive_overflow_flag,
    input wire logic port_interrupt_flag,
    input wire logic update_address_flag,
    input wire logic port_irq
);
    import ssa_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // The acknowledge begins when sda_oe rises; a match write ends the stretch.
    sequence ack_start; $rose(sda_oe); endsequence
    sequence let_go; !scl_oe && !update_address_flag; endsequence
    // An acknowledge is only given for a byte that was just loaded into a clear buffer.
    ack_taken_a: assert property (ack_start |-> buffer_full_flag && !receive_overflow_flag)
        else $error("acknowledge given for a refused byte");
    // The acknowledge spans a whole SCL high phase, far more than eight cycles.
    ack_length_a: assert property (ack_start |=> sda_oe [*8])
        else $error("acknowledge pulse too short");
    irq_on_a: assert property (port_interrupt_flag && port_int_enable |=> port_irq)
        else $error("interrupt output missing");
    irq_off_a: assert property (!(port_interrupt_flag && port_int_enable) |=> !port_irq)
        else $error("interrupt output without flag and enable");
    flag_hold_a: assert property (port_interrupt_flag && !int_flag_clear |=> port_interrupt_flag)
        else $error("interrupt flag cleared by itself");
    ovf_hold_a: assert property (receive_overflow_flag && !overflow_clear |=> receive_overflow_flag)
        else $error("overflow flag cleared by itself");
    buf_load_a: assert property ($changed(receive_buffer) |-> buffer_full_flag)
        else $error("buffer changed without becoming full");
    stretch_end_a: assert property (match_write |=> let_go)
        else $error("match write did not release the clock");
endmodule // ssa_assertions

//--- sim/ssa_master_model.sv
// Behavioural bus master that frames bytes on the open-drain bus.
`timescale 1ns/100ps
module ssa_master_model (
    input wire logic ref_clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_drv,
    output logic sda_drv
);
    // Released lines float high through the pull-ups; the clock stands still between frames.
    initial {scl_drv, sda_drv} = 2'b11;
    // Clock stretches that never end are counted here for the bench's verdict.
    int stalls = 0;
    // Half a link clock period: 16 cycles of 5 ns give 80 ns.
    task automatic half();
        repeat (16) @(negedge ref_clk);
    endtask
    // A stretched clock is waited out, but only for a bounded time.
    // The first wait lets the wired level settle before it is looked at.
    task automatic rise();
        scl_drv = 1'b1;
        @(negedge ref_clk);
        for (int n = 0; n < 4000 && scl !== 1'b1; n++) @(negedge ref_clk);
        if (scl !== 1'b1) stalls++;
        repeat (15) @(negedge ref_clk);
    endtask
    // Data changes a quarter period after SCL falls, so no false Start or Stop is seen.
    // Low and high phases of 80 ns each give the 160 ns link clock.
    task automatic one_bit(input logic v, output logic seen);
        repeat (8) @(negedge ref_clk);
        sda_drv = v;
        repeat (8) @(negedge ref_clk);
        rise();
        seen = sda;
        scl_drv = 1'b0;
    endtask
    task automatic start();
        sda_drv = 1'b1;
        rise();
        sda_drv = 1'b0;
        half();
        scl_drv = 1'b0;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) one_bit(b[i], s);
        one_bit(1'b1, s);
        ack = (s === 1'b0);
    endtask
    task automatic stop();
        half();
        sda_drv = 1'b0;
        half();
        rise();
        sda_drv = 1'b1;
        half();
    endtask
endmodule // ssa_master_model

//--- sim/testbench.sv
// Self-checking bench for the slave address and receive path.
`timescale 1ns/100ps
`include "ssa_defs.svh"
module testbench;
    import ssa_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, port_enable_bit = 1'b0, port_int_enable = 1'b0;
    logic match_write = 1'b0, buffer_read = 1'b0, int_flag_clear = 1'b0, overflow_clear = 1'b0;
    ssa_mode_t port_mode = `SSA_MODE_7BIT;
    ssa_byte_t match_wdata = 8'h00;
    ssa_byte_t receive_buffer, address_match_register, d;
    logic scl_out, scl_oe, sda_out, sda_oe, scl_drv, sda_drv, buffer_full_flag;
    logic receive_overflow_flag, port_interrupt_flag, update_address_flag;
    logic read_write_flag, data_address_flag, port_irq;
    int failures = 0, num_checks = 0, seed = 94;
    ssa_byte_t exp_q[$];
    // Open-drain wires: low when either side pulls, high through the pull-up otherwise.
    wire logic scl = scl_drv & !scl_oe;
    wire logic sda = sda_drv & !sda_oe;
    ssa_slave_rx i_ssa_slave_rx (.scl_in(scl), .sda_in(sda), .*);
    ssa_master_model i_ssa_master_model (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic check(input ssa_byte_t seen, input ssa_byte_t exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge ref_clk) s = 1'b1;
        @(negedge ref_clk) s = 1'b0;
    endtask
    task automatic set_match(input ssa_byte_t v);
        match_wdata = v;
        pulse(match_write);
        check(address_match_register, v);
    endtask
    // One byte; the flag settles a few cycles after SCL falls, and firmware then clears it.
    task automatic xfer(input ssa_byte_t b, input logic ack, input logic irq, input ssa_byte_t e);
        logic a;
        if (irq) exp_q.push_back(e);
        i_ssa_master_model.send(b, a);
        repeat (8) @(negedge ref_clk);
        check(a, ack);
        check(port_interrupt_flag, irq);
        check(port_irq, irq);
        check({scl_out, sda_out}, 2'b00);
        pulse(int_flag_clear);
    endtask
    // Each raised interrupt flag retires the oldest expected buffer value.
    // A flag that rises with no note waiting is itself a mismatch.
    always @(posedge port_interrupt_flag) begin
        @(negedge ref_clk);
        if (exp_q.size() == 0) check(8'h01, 8'h00);
        else check(receive_buffer, exp_q.pop_front());
    end
    task automatic give_verdict();
        check(8'(i_ssa_master_model.stalls), 8'h00);
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        {port_enable_bit, port_int_enable} = 2'b11;
        set_match(8'h6C);
        // Address, one good data byte, then two bytes refused while full or overflowed.
        i_ssa_master_model.start();
        xfer(8'h6C, 1'b1, 1'b1, 8'h6C);
        check(read_write_flag, 1'b0);
        pulse(buffer_read);
        d = 8'($random(seed));
        xfer(d, 1'b1, 1'b1, d);
        check(data_address_flag, 1'b1);
        xfer(~d, 1'b0, 1'b1, d);
        check(receive_overflow_flag, 1'b1);
        pulse(buffer_read);
        check(buffer_full_flag, 1'b0);
        check(receive_overflow_flag, 1'b1);
        xfer(8'h3C, 1'b0, 1'b1, d);
        // A matching address under overflow is flagged but not acknowledged.
        i_ssa_master_model.start();
        xfer(8'h6C, 1'b0, 1'b1, d);
        check(data_address_flag, 1'b0);
        pulse(overflow_clear);
        i_ssa_master_model.stop();
        $display("receive test done");
        // A foreign address leaves the port deaf, even to its own address, until a Start.
        i_ssa_master_model.start();
        xfer(8'h22, 1'b0, 1'b0, 8'h00);
        xfer(8'h6C, 1'b0, 1'b0, 8'h00);
        check(buffer_full_flag, 1'b0);
        i_ssa_master_model.stop();
        $display("mismatch test done");
        // Ten-bit write: each address byte stretches SCL until the match is rewritten.
        port_mode = `SSA_MODE_10BIT;
        set_match(8'hF6);
        i_ssa_master_model.start();
        xfer(8'hF6, 1'b1, 1'b1, 8'hF6);
        check({scl_oe, update_address_flag}, 2'b11);
        pulse(buffer_read);
        set_match(8'h5A);
        check(scl_oe, 1'b0);
        xfer(8'h5A, 1'b1, 1'b1, 8'h5A);
        check(update_address_flag, 1'b1);
        pulse(buffer_read);
        set_match(8'hF6);
        check(update_address_flag, 1'b0);
        // Repeated Start and the high byte as a read: flags set, no update, no stretch.
        port_mode = `SSA_MODE_10BIT_SP;
        i_ssa_master_model.start();
        xfer(8'hF7, 1'b1, 1'b1, 8'hF7);
        check({scl_oe, update_address_flag, read_write_flag}, 3'b001);
        pulse(buffer_read);
        i_ssa_master_model.stop();
        $display("ten-bit test done");
        // A write address clears the direction bit; a reset mid-frame abandons the frame.
        port_mode = `SSA_MODE_7BIT_SP;
        set_match(8'h6C);
        i_ssa_master_model.start();
        xfer(8'h6C, 1'b1, 1'b1, 8'h6C);
        check(read_write_flag, 1'b0);
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        check(buffer_full_flag, 1'b0);
        check(receive_buffer, 8'h00);
        check(address_match_register, 8'h00);
        set_match(8'h6C);
        // With no fresh Start the port stays idle, even for its own address.
        xfer(8'h6C, 1'b0, 1'b0, 8'h00);
        check(buffer_full_flag, 1'b0);
        i_ssa_master_model.stop();
        $display("reset test done");
        give_verdict();
    end
    // Twelve bytes of about 1.5 us each; a hang is cut short well beyond that.
    initial begin
        #100us;
        failures++;
        give_verdict();
    end
endmodule // testbench
bind ssa_slave_rx ssa_assertions i_ssa_assertions (.*);
